// file: hdl/tbip_pkg.sv
// Overview of operation
// [R01] Pin level register is read-only, writes ignored
// [R02] Bit 1 second pin, bit 0 first pin
// [R03] Bit pair decode: hiz, pull-down, pull-up, hiz
// [R04] Low control byte: reset zero, byte/word access
// [R05] High control byte: read/write, reset zero
// [R06] Each pin's termination chosen independently
// [R07] Reset leaves both pins high impedance
// [R08] Pin use follows oscillator mode field only
// [R09] Crystal mode hands both pins to oscillator
// [R10] External clock: first pin clock, second input
// [R11] Software sets hiz before crystal use
// [R12] Software should set hiz for clock input
// [R13] Crystal mode: oscillator drives second pin out
// [R14] Pin levels pass a two-stage synchroniser
package tbip_pkg;

    // ==========================================
    // Bus shape
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int PIN_COUNT = 2;

    // ==========================================
    // Register map
    localparam logic [15:0] ADDR_PIN_LEVEL = 16'hf208;
    localparam logic [15:0] ADDR_TERM_LO = 16'hf20a;
    localparam logic [15:0] ADDR_TERM_HI = 16'hf20b;
    localparam logic [15:0] ADDR_LANE_STEP = 16'h0001;
    localparam logic [7:0] RST_TERM_LO = 8'h00;
    localparam logic [7:0] RST_TERM_HI = 8'h00;
    localparam logic [15:0] RST_RDATA = 16'h0000;
    localparam int LVL_FIRST_BIT = 0;
    localparam int LVL_SECOND_BIT = 1;

    // ==========================================
    // Termination codes, {high bit, low bit}
    localparam logic [1:0] TERM_HIZ = 2'h0;
    localparam logic [1:0] TERM_PD = 2'h1;
    localparam logic [1:0] TERM_PU = 2'h2;

    // ==========================================
    // Oscillator mode field codes
    localparam logic [1:0] OSC_MODE_XTAL = 2'h1;
    localparam logic [1:0] OSC_MODE_EXT = 2'h2;

    typedef enum logic [2:0] {
        OWN_PORT = 3'h1,
        OWN_XTAL = 3'h2,
        OWN_EXT = 3'h4
    } tbip_own_e;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic word;
        logic wr;
        logic rd;
    } tbip_req_s;

    typedef struct packed {
        logic [7:0] term_lo;
        logic [7:0] term_hi;
        logic [15:0] rdata;
        tbip_own_e own;
        logic [1:0] pull_up;
        logic [1:0] pull_dn;
        logic osc_in_sel;
        logic osc_out_en;
    } tbip_state_s;

    // Only the mode field decides who owns the pins
    function automatic tbip_own_e own_of(input logic [1:0] mode);
        if (mode == OSC_MODE_XTAL) begin
            return OWN_XTAL;
        end else if (mode == OSC_MODE_EXT) begin
            return OWN_EXT;
        end
        return OWN_PORT;
    endfunction

endpackage

// file: hdl/tbip_sync.sv
`timescale 1ns/1ns
`default_nettype none
module tbip_sync
    import tbip_pkg::*;
#(
    parameter int WIDTH = PIN_COUNT
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] hold;
    } tbip_sync_s;

    tbip_sync_s st_r;
    tbip_sync_s st_nxt;

    // ==========================================
    // Two stages; first stage feeds only the second
    always_comb begin
        st_nxt = st_r;
        st_nxt.meta = async_in;
        st_nxt.hold = st_r.meta;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.hold;

endmodule
`default_nettype wire

// file: hdl/tbip_term_dec.sv
`timescale 1ns/1ns
`default_nettype none
module tbip_term_dec
    import tbip_pkg::*;
(
    // Control bits
    input wire logic term_hi,
    input wire logic term_lo,
    input wire logic osc_owned,
    // Resistor enables
    output logic pull_up,
    output logic pull_dn
);

    // ==========================================
    // Code 3 is high impedance like code 0
    always_comb begin
        pull_up = 1'b0;
        pull_dn = 1'b0;
        // Resistors off while oscillator owns the pin, no load on the crystal
        if (!osc_owned) begin
            pull_up = ({term_hi, term_lo} == TERM_PU);
            pull_dn = ({term_hi, term_lo} == TERM_PD);
        end
    end

endmodule
`default_nettype wire

// file: hdl/tbip_top.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module tbip_top
    import tbip_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_word,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Oscillator mode field and oscillator side
    input wire logic [1:0] osc_mode,
    input wire logic osc_drive,
    output logic osc_in_sel,
    output logic osc_out_en,
    // First pin, input only
    input wire logic first_pin_in,
    // Second pin, two-way
    input wire logic second_pin_in,
    output logic second_pin_out,
    output logic second_pin_oe,
    // Termination resistors, bit 0 first pin
    output logic [1:0] pin_pull_up,
    output logic [1:0] pin_pull_dn
);

    tbip_state_s st_r;
    tbip_state_s st_nxt;
    tbip_req_s req;
    tbip_own_e own_nxt;
    logic [1:0] pin_raw;
    logic [1:0] pin_lvl;
    logic [1:0] lvl_masked;
    logic [1:0] dec_up;
    logic [1:0] dec_dn;
    logic [1:0] osc_owned;

    assign req = '{addr: reg_addr, wdata: reg_wdata, word: reg_word, wr: reg_wr, rd: reg_rd};
    assign pin_raw = {second_pin_in, first_pin_in};

    // ==========================================
    // Pin sampling
    // [R14] Synchronised pin levels
    tbip_sync #(
        .WIDTH(PIN_COUNT)
    ) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .async_in(pin_raw),
        .sync_out(pin_lvl)
    );

    // ==========================================
    // Pin ownership
    // [R08] Mode field only
    assign own_nxt = own_of(osc_mode);

    // [R09] [R10] Oscillator claims pins
    assign osc_owned[LVL_FIRST_BIT] = (own_nxt != OWN_PORT);
    assign osc_owned[LVL_SECOND_BIT] = (own_nxt == OWN_XTAL);

    // A pin owned by the oscillator reads low; its level means nothing to software
    always_comb begin
        lvl_masked = pin_lvl;
        if (st_r.own != OWN_PORT) begin
            lvl_masked[LVL_FIRST_BIT] = 1'b0;
        end
        if (st_r.own == OWN_XTAL) begin
            lvl_masked[LVL_SECOND_BIT] = 1'b0;
        end
    end

    // ==========================================
    // Termination decode
    // [R06] One decoder per pin
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++) begin : g_term
            // [R03] Bit pair decode
            tbip_term_dec u_dec (
                .term_hi(st_r.term_hi[gi]),
                .term_lo(st_r.term_lo[gi]),
                .osc_owned(osc_owned[gi]),
                .pull_up(dec_up[gi]),
                .pull_dn(dec_dn[gi])
            );
        end
    endgenerate

    // ==========================================
    // Register access helpers
    function automatic logic [7:0] read_byte(
        input logic [15:0] a,
        input logic [7:0] lo,
        input logic [7:0] hi,
        input logic [1:0] lvl
    );
        logic [7:0] d;
        d = 8'h00;
        // [R02] Level bits
        if (a == ADDR_PIN_LEVEL) begin
            d[LVL_FIRST_BIT] = lvl[LVL_FIRST_BIT];
            d[LVL_SECOND_BIT] = lvl[LVL_SECOND_BIT];
        end else if (a == ADDR_TERM_LO) begin
            d = lo;
        end else if (a == ADDR_TERM_HI) begin
            d = hi;
        end
        return d;
    endfunction

    // ==========================================
    // Next state
    always_comb begin
        logic [15:0] hi_addr;
        logic [7:0] lane_lo;
        logic [7:0] lane_hi;
        hi_addr = 16'(req.addr + ADDR_LANE_STEP);
        lane_lo = req.wdata[7:0];
        lane_hi = req.wdata[15:8];
        st_nxt = st_r;

        // [R01] Level address has no write path
        if (req.wr) begin
            // [R04] Byte or word write
            if (req.addr == ADDR_TERM_LO) begin
                st_nxt.term_lo = lane_lo;
            end
            // [R05] High control byte
            if (req.addr == ADDR_TERM_HI) begin
                st_nxt.term_hi = lane_lo;
            end
            if (req.word && hi_addr == ADDR_TERM_HI) begin
                st_nxt.term_hi = lane_hi;
            end
        end

        // Read data stand one cycle only
        st_nxt.rdata = RST_RDATA;
        if (req.rd) begin
            st_nxt.rdata[7:0] = read_byte(req.addr, st_r.term_lo, st_r.term_hi, lvl_masked);
            if (req.word) begin
                st_nxt.rdata[15:8] = read_byte(hi_addr, st_r.term_lo, st_r.term_hi, lvl_masked);
            end
        end

        // Ownership state follows the mode field
        unique case (own_nxt)
            OWN_PORT: begin
                st_nxt.own = OWN_PORT;
                st_nxt.osc_in_sel = 1'b0;
                st_nxt.osc_out_en = 1'b0;
            end
            // [R09] [R13] Both pins to oscillator
            OWN_XTAL: begin
                st_nxt.own = OWN_XTAL;
                st_nxt.osc_in_sel = 1'b1;
                st_nxt.osc_out_en = 1'b1;
            end
            // [R10] Second pin stays an input
            OWN_EXT: begin
                st_nxt.own = OWN_EXT;
                st_nxt.osc_in_sel = 1'b1;
                st_nxt.osc_out_en = 1'b0;
            end
        endcase

        st_nxt.pull_up = dec_up;
        st_nxt.pull_dn = dec_dn;
    end

    // ==========================================
    // State register
    always_ff @(posedge core_clk) begin
        // [R07] Reset to high impedance
        if (sys_rst) begin
            st_r.term_lo <= RST_TERM_LO;
            st_r.term_hi <= RST_TERM_HI;
            st_r.rdata <= RST_RDATA;
            st_r.own <= OWN_PORT;
            st_r.pull_up <= 2'h0;
            st_r.pull_dn <= 2'h0;
            st_r.osc_in_sel <= 1'b0;
            st_r.osc_out_en <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign reg_rdata = st_r.rdata;
    assign osc_in_sel = st_r.osc_in_sel;
    assign osc_out_en = st_r.osc_out_en;
    assign pin_pull_up = st_r.pull_up;
    assign pin_pull_dn = st_r.pull_dn;
    // [R13] Oscillator drives second pin
    assign second_pin_oe = st_r.osc_out_en;
    // Oscillator output is not re-timed; a flop would halve its rate
    assign second_pin_out = st_r.osc_out_en & osc_drive;

    // ==========================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    ro_level_write_a: assert property ( // [R01]
        req.wr && !req.word && req.addr == ADDR_PIN_LEVEL
        |=> $stable(st_r.term_lo) && $stable(st_r.term_hi)
    ) else $error("write to level register changed control bytes");

    level_read_a: assert property ( // [R02]
        req.rd && req.addr == ADDR_PIN_LEVEL && st_r.own == OWN_PORT
        ##1 st_r.own == OWN_PORT
        |-> reg_rdata == {14'h0000, $past(pin_lvl)}
    ) else $error("level read does not show pin levels");

    sync_delay_a: assert property ( // [R14]
        !$past(sys_rst) && !$past(sys_rst, 2) |-> pin_lvl == $past(pin_raw, 2)
    ) else $error("pin level not two cycles behind pin");

    first_pull_dn_a: assert property ( // [R03]
        own_nxt == OWN_PORT && st_r.term_hi[0] == 1'b0 && st_r.term_lo[0] == 1'b1
        |=> pin_pull_dn[0] && !pin_pull_up[0]
    ) else $error("first pin pull-down code not decoded");

    second_pull_up_a: assert property ( // [R06]
        own_nxt == OWN_PORT && st_r.term_hi[1] && !st_r.term_lo[1]
        |=> pin_pull_up[1] && !pin_pull_dn[1]
    ) else $error("second pin pull-up code not decoded");

    hiz_codes_a: assert property ( // [R03]
        st_r.term_hi[0] == st_r.term_lo[0] |=> !pin_pull_up[0] && !pin_pull_dn[0]
    ) else $error("equal bits must leave first pin high impedance");

    word_write_a: assert property ( // [R04]
        req.wr && req.word && req.addr == ADDR_TERM_LO
        |=> st_r.term_lo == $past(req.wdata[7:0]) && st_r.term_hi == $past(req.wdata[15:8])
    ) else $error("word write did not load both control bytes");

    hi_byte_write_a: assert property ( // [R05]
        req.wr && !req.word && req.addr == ADDR_TERM_HI
        |=> st_r.term_hi == $past(req.wdata[7:0]) ##1 reg_rdata == 16'h0000 || $past(req.rd)
    ) else $error("high control byte write lost");

    reset_hiz_a: assert property ( // [R07]
        $fell(sys_rst) |-> st_r.term_lo == RST_TERM_LO && st_r.term_hi == RST_TERM_HI
            && pin_pull_up == 2'h0 && pin_pull_dn == 2'h0
    ) else $error("reset did not leave pins high impedance");

    own_follows_mode_a: assert property ( // [R08]
        st_r.own != $past(st_r.own) |-> st_r.own == own_of($past(osc_mode))
    ) else $error("pin ownership changed without mode field");

    xtal_mode_a: assert property ( // [R09]
        osc_mode == OSC_MODE_XTAL |=> second_pin_oe && osc_in_sel && pin_pull_up == 2'h0
            && pin_pull_dn == 2'h0
    ) else $error("crystal mode did not hand both pins over");

    ext_mode_a: assert property ( // [R10]
        osc_mode == OSC_MODE_EXT [*2] |-> osc_in_sel && !second_pin_oe
    ) else $error("external clock mode claimed second pin");

endmodule
`default_nettype wire

// file: tb/tbip_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
module tbip_pin_model
    import tbip_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Board side
    input wire logic [1:0] ext_en,
    input wire logic [1:0] ext_lvl,
    input wire logic clk_src_on,
    // Block side
    input wire logic [1:0] pin_pull_up,
    input wire logic [1:0] pin_pull_dn,
    input wire logic second_pin_out,
    input wire logic second_pin_oe,
    output logic first_pin_in,
    output logic second_pin_in
);
    logic [1:0] float_r = 2'h1;
    logic src_r = 1'h0;
    logic [1:0] lvl;
    // ==========================================
    // Undriven pins wander, so no lucky zero
    always @(posedge core_clk) begin
        float_r <= ~float_r;
        src_r <= clk_src_on ? ~src_r : 1'h0;
    end
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (ext_en[i]) begin
                lvl[i] = ext_lvl[i];
            end else if (pin_pull_up[i]) begin
                lvl[i] = 1'h1;
            end else if (pin_pull_dn[i]) begin
                lvl[i] = 1'h0;
            end else begin
                lvl[i] = float_r[i];
            end
        end
        // Resonator or clock source wins the first pin
        if (clk_src_on) begin
            lvl[0] = src_r;
        end
        // Block drives the second pin when enabled
        if (second_pin_oe) begin
            lvl[1] = second_pin_out;
        end
    end
    assign first_pin_in = lvl[0];
    assign second_pin_in = lvl[1];
endmodule
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench
    import tbip_pkg::*;
;
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic word;
        logic [1:0] up;
        logic [1:0] dn;
    } tbip_row_s;
    localparam tbip_row_s ROWS [7] = '{
        '{8'h00, 8'h00, 1'h1, 2'h0, 2'h0}, '{8'h01, 8'h00, 1'h0, 2'h0, 2'h1},
        '{8'h03, 8'h00, 1'h1, 2'h0, 2'h3}, '{8'h00, 8'h03, 1'h0, 2'h3, 2'h0},
        '{8'h03, 8'h03, 1'h1, 2'h0, 2'h0}, '{8'h01, 8'h02, 1'h0, 2'h2, 2'h1},
        '{8'h02, 8'h01, 1'h1, 2'h1, 2'h2}};
    logic core_clk, sys_rst, reg_word, reg_wr, reg_rd, osc_drive, osc_in_sel, osc_out_en;
    logic first_pin_in, second_pin_in, second_pin_out, second_pin_oe, clk_src_on;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic [1:0] osc_mode, pin_pull_up, pin_pull_dn, ext_en, ext_lvl;
    int err_count = 0;
    int cmp_count = 0;

    tbip_top u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_word(reg_word), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .osc_mode(osc_mode), .osc_drive(osc_drive),
        .osc_in_sel(osc_in_sel), .osc_out_en(osc_out_en), .first_pin_in(first_pin_in),
        .second_pin_in(second_pin_in), .second_pin_out(second_pin_out),
        .second_pin_oe(second_pin_oe), .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn));
    tbip_pin_model u_pins (.core_clk(core_clk), .ext_en(ext_en), .ext_lvl(ext_lvl),
        .clk_src_on(clk_src_on), .pin_pull_up(pin_pull_up), .pin_pull_dn(pin_pull_dn),
        .second_pin_out(second_pin_out), .second_pin_oe(second_pin_oe),
        .first_pin_in(first_pin_in), .second_pin_in(second_pin_in));

    // ==========================================
    // Clock and watchdog
    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        err_count++;
        conclude();
    end

    // ==========================================
    // Bus and compare helpers
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_word <= w;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    // Data stands one cycle only, then must fall back to zero
    task automatic rd(input logic [15:0] a, input logic w, input logic [15:0] exp, input string name);
        @(posedge core_clk);
        reg_addr <= a;
        reg_word <= w;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1;
        check(name, exp, reg_rdata);
        idle(1);
        check("read idle", 16'h0000, reg_rdata);
    endtask
    task automatic conclude();
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        sys_rst = 1'h1;
        {reg_addr, reg_wdata, reg_word, reg_wr, reg_rd} = '0;
        {osc_mode, osc_drive, ext_en, ext_lvl, clk_src_on} = '0;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'h0;
        idle(1);
        check("reset pulls", 16'h0000, {12'h000, pin_pull_up, pin_pull_dn});
        check("reset osc", 16'h0000, {13'h0000, osc_in_sel, osc_out_en, second_pin_oe});
        rd(ADDR_TERM_LO, 1'h1, {RST_TERM_HI, RST_TERM_LO}, "term word");
        foreach (ROWS[i]) begin
            if (ROWS[i].word) begin
                wr(ADDR_TERM_LO, {ROWS[i].hi, ROWS[i].lo}, 1'h1);
            end else begin
                wr(ADDR_TERM_LO, {8'h00, ROWS[i].lo}, 1'h0);
                wr(ADDR_TERM_HI, {8'h00, ROWS[i].hi}, 1'h0);
            end
            idle(2);
            check("pull up", {14'h0000, ROWS[i].up}, {14'h0000, pin_pull_up});
            check("pull down", {14'h0000, ROWS[i].dn}, {14'h0000, pin_pull_dn});
            rd(ADDR_TERM_LO, 1'h1, {ROWS[i].hi, ROWS[i].lo}, "term word");
            rd(ADDR_TERM_HI, 1'h0, {8'h00, ROWS[i].hi}, "term high");
        end
        // Pulls alone set the level when nothing else drives
        wr(ADDR_TERM_LO, 16'h0300, 1'h1);
        idle(3);
        rd(ADDR_PIN_LEVEL, 1'h0, 16'h0003, "pulled level");
        wr(ADDR_TERM_LO, 16'h0000, 1'h1);
        ext_en <= 2'h3;
        for (int v = 0; v < 4; v++) begin
            @(posedge core_clk);
            ext_lvl <= v[1:0];
            idle(3);
            rd(ADDR_PIN_LEVEL, 1'h0, {14'h0000, v[1:0]}, "pin level");
        end
        wr(ADDR_PIN_LEVEL, 16'h00fc, 1'h0);
        rd(ADDR_PIN_LEVEL, 1'h1, 16'h0003, "level word");
        rd(16'hf20c, 1'h0, 16'h0000, "unmapped");
        @(posedge core_clk);
        ext_en <= 2'h1;
        ext_lvl <= 2'h1;
        for (int m = 0; m < 4; m++) begin
            // Termination cleared before crystal mode only; the other modes keep the second pin pull-up
            wr(ADDR_TERM_LO, (m == 1) ? 16'h0000 : 16'h0200, 1'h1);
            osc_mode <= m[1:0];
            osc_drive <= m[0];
            clk_src_on <= (m == 1) || (m == 2);
            idle(3);
            check("osc in sel", {15'h0000, m == 1 || m == 2}, {15'h0000, osc_in_sel});
            check("osc out en", {15'h0000, m == 1}, {15'h0000, osc_out_en});
            check("pin drive", {14'h0000, m == 1, m == 1}, {14'h0000, second_pin_oe, second_pin_out});
            check("osc pulls", {14'h0000, (m == 1) ? 2'h0 : 2'h2}, {14'h0000, pin_pull_up});
            rd(ADDR_PIN_LEVEL, 1'h0, {14'h0000, (m == 1) ? 2'h0 : (m == 2) ? 2'h2 : 2'h3}, "osc level");
        end
        // Crystal mode with the oscillator output low must show a low pin
        wr(ADDR_TERM_LO, 16'h0000, 1'h1);
        osc_mode <= OSC_MODE_XTAL;
        osc_drive <= 1'h0;
        idle(2);
        check("pin out low", 16'h0002, {14'h0000, second_pin_oe, second_pin_out});
        @(posedge core_clk);
        osc_mode <= 2'h0;
        clk_src_on <= 1'h0;
        wr(ADDR_TERM_LO, 16'h0201, 1'h1);
        idle(2);
        @(posedge core_clk);
        sys_rst <= 1'h1;
        idle(2);
        @(posedge core_clk);
        sys_rst <= 1'h0;
        idle(1);
        check("rerun pulls", 16'h0000, {12'h000, pin_pull_up, pin_pull_dn});
        rd(ADDR_TERM_LO, 1'h1, 16'h0000, "rerun word");
        conclude();
    end
endmodule
`default_nettype wire
